// [design/asi_pkg.sv]
// constants, types and state codes for the converter serial readout block
// assumes a single 20 MHz mclk domain; all pins arrive asynchronous to it
// Notes on behaviour
// - trigger rise samples select line, picks mode
// - select tied to trigger resolves chain mode
// - optional start bit flags conversion done
// - select mode: start bit if line low at end
// - chain mode: start bit if clock high at trigger
// - three-wire variant, trigger frames the readout
// - four-wire variant, select line frames readout
// - chain mode passes upstream data through register
// - conversion timed by internal clock only
// - two's complement, clamp over and underrange codes
// - conversion completes; output released at trigger rise
// - msb on frame start, shift on falls, release
package asi_pkg;
    localparam int CODE_W = 18;
    localparam int SH_W = CODE_W + 1;
    localparam int CLK_NS = 50;
    // longest conversion time of the internal sequencer
    localparam int CONV_MAX_NS = 710;
    localparam int CONV_CYC = (CONV_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 5;
    localparam int CNT_W = 5;
    localparam logic [CODE_W-1:0] CODE_POS_FS = 18'h1FFFF;
    localparam logic [CODE_W-1:0] CODE_NEG_FS = 18'h20000;
    localparam logic [CNT_W-1:0] BITS_PLAIN = 5'h12;
    localparam logic [CNT_W-1:0] BITS_START = 5'h13;
    localparam logic START_CS = 1'h0;
    localparam logic START_CHAIN = 1'h1;
    localparam int SYNC_W = 3;

    typedef struct packed {
        logic chain;
        logic busy_en;
    } asi_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CONV = 3'h2,
        ST_READY = 3'h4
    } asi_state_t;
endpackage : asi_pkg

// [design/asi_serial_if.sv]
// serial readout side of an 18-bit successive-approximation converter
// assumes the analog core presents its code and range flags on mclk;
// trigger, select/chain and serial clock pins are asynchronous and synchronised here
`timescale 1ns/10ps
module asi_serial_if #(
    parameter int CONV_CYC = asi_pkg::CONV_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic conversion_trigger,
    input wire logic select_chain_input,
    input wire logic sclk,
    input wire logic [asi_pkg::CODE_W-1:0] core_code,
    input wire logic core_over,
    input wire logic core_under,
    output logic result_output,
    output logic result_output_oe_n,
    output logic conv_busy,
    output logic chain_mode,
    output logic busy_bit_en
);
    // pin synchronisers: stage 0 feeds only stage 1
    logic [asi_pkg::SYNC_W-1:0] cnv_p, sdi_p, sck_p;
    logic [asi_pkg::SYNC_W-1:0] next_cnv_p, next_sdi_p, next_sck_p;
    logic cnv_s, sdi_s, sdi_d, sck_d, cnv_rise, sck_fall;

    always_comb begin
        next_cnv_p = {cnv_p[1:0], conversion_trigger};
        next_sdi_p = {sdi_p[1:0], select_chain_input};
        next_sck_p = {sck_p[1:0], sclk};
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnv_p <= 3'h7;
            sdi_p <= 3'h7;
            sck_p <= 3'h0;
        end else begin
            cnv_p <= next_cnv_p;
            sdi_p <= next_sdi_p;
            sck_p <= next_sck_p;
        end
    end

    // edges seen on the synchronised copies; sdi_d and sck_d are the levels
    // one sample before the trigger edge, so a select line wired to the
    // trigger is still read low and chain mode wins
    assign cnv_s = cnv_p[1];
    assign sdi_s = sdi_p[1];
    assign sdi_d = sdi_p[2];
    assign sck_d = sck_p[2];
    assign cnv_rise = cnv_s & ~cnv_p[2];
    assign sck_fall = ~sck_p[1] & sck_p[2];

    // clamp the core code at both ends of the two's complement range
    function automatic logic [asi_pkg::CODE_W-1:0] clamp_code(
        input logic [asi_pkg::CODE_W-1:0] code,
        input logic over,
        input logic under
    );
        if (over)
            return asi_pkg::CODE_POS_FS;
        else if (under)
            return asi_pkg::CODE_NEG_FS;
        else
            return code;
    endfunction : clamp_code

    asi_pkg::asi_state_t state, next_state;
    asi_pkg::asi_mode_t mode, next_mode;
    logic [asi_pkg::TMR_W-1:0] timer, next_timer;
    logic [asi_pkg::CNT_W-1:0] cnt, next_cnt;
    logic [asi_pkg::SH_W-1:0] sh, next_sh;
    logic frame, conv_end, busy_now, drive;
    logic [asi_pkg::CODE_W-1:0] code_now;
    logic [asi_pkg::CNT_W-1:0] limit;

    localparam int TMR_W = asi_pkg::TMR_W;

    // cs mode frames on either line low: 3-wire keeps select high so the
    // trigger frames, 4-wire keeps the trigger high so select frames
    assign frame = mode.chain ? ~cnv_s : (~cnv_s | ~sdi_s);
    assign conv_end = (state == asi_pkg::ST_CONV) && (timer == 5'h01);
    assign busy_now = mode.chain ? mode.busy_en : (~cnv_s | ~sdi_s);
    assign code_now = clamp_code(core_code, core_over, core_under);
    assign limit = mode.busy_en ? asi_pkg::BITS_START : asi_pkg::BITS_PLAIN;

    // sequencer: trigger, internal conversion timing, readout shifting
    always_comb begin
        next_state = state;
        next_mode = mode;
        next_timer = timer;
        next_cnt = cnt;
        next_sh = sh;
        case (state)
            asi_pkg::ST_IDLE: begin
                next_cnt = cnt;
            end
            asi_pkg::ST_CONV: begin
                // runs on mclk alone; serial clock is not looked at
                next_timer = timer - 5'h01;
                if (conv_end) begin
                    next_state = asi_pkg::ST_READY;
                    next_cnt = 5'h00;
                    if (!mode.chain)
                        next_mode.busy_en = busy_now;
                    // start bit ahead of the msb when enabled
                    if (busy_now)
                        next_sh = {mode.chain ? asi_pkg::START_CHAIN : asi_pkg::START_CS,
                                   code_now};
                    else
                        next_sh = {code_now, 1'h0};
                end
            end
            asi_pkg::ST_READY: begin
                if (frame && sck_fall) begin
                    if (mode.chain) begin
                        // without a start bit the lowest cell is a spare zero;
                        // skip it so the upstream msb follows our lsb directly
                        if (mode.busy_en)
                            next_sh = {sh[asi_pkg::SH_W-2:0], sdi_s};
                        else
                            next_sh = {sh[asi_pkg::SH_W-2:1], sdi_s, 1'h0};
                    end else begin
                        next_sh = {sh[asi_pkg::SH_W-2:0], 1'h0};
                        if (cnt != limit)
                            next_cnt = cnt + 5'h01;
                    end
                end
            end
            default: begin
                next_state = asi_pkg::ST_IDLE;
            end
        endcase
        // a running conversion ignores further trigger edges
        if (cnv_rise && state != asi_pkg::ST_CONV) begin
            next_state = asi_pkg::ST_CONV;
            next_timer = TMR_W'(CONV_CYC);
            next_mode.chain = ~sdi_d;
            next_mode.busy_en = ~sdi_d & sck_d;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= asi_pkg::ST_IDLE;
            mode <= 2'h0;
            timer <= 5'h00;
            cnt <= 5'h00;
            sh <= 19'h00000;
        end else begin
            state <= next_state;
            mode <= next_mode;
            timer <= next_timer;
            cnt <= next_cnt;
            sh <= next_sh;
        end
    end

    // output pin: released during conversion and, in cs mode only, after the last bit
    assign drive = (state == asi_pkg::ST_READY) && frame
                   && (mode.chain || cnt != limit);
    assign result_output_oe_n = ~drive;
    assign result_output = sh[asi_pkg::SH_W-1];
    assign conv_busy = (state == asi_pkg::ST_CONV);
    assign chain_mode = mode.chain;
    assign busy_bit_en = mode.busy_en;

    // checks
    default clocking chk_clk @(posedge mclk);
    endclocking
    default disable iff (rst);

    // helper: busy cycles counted so the conversion length is checked exactly
    logic [asi_pkg::TMR_W-1:0] busy_len, next_busy_len;

    always_comb begin
        next_busy_len = conv_busy ? busy_len + 5'h01 : 5'h00;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            busy_len <= 5'h00;
        else
            busy_len <= next_busy_len;
    end

    chk_mode_select: assert property (
        cnv_rise && !conv_busy |=> chain_mode == !$past(sdi_d))
        else $error("mode not taken from select level at trigger");
    chk_tied_chain: assert property (
        cnv_rise && !conv_busy && !sdi_d |=> chain_mode)
        else $error("low select at trigger did not give chain mode");
    chk_start_bit: assert property (
        conv_end && busy_now && !mode.chain |=> result_output == asi_pkg::START_CS)
        else $error("start bit value wrong");
    chk_cs_busy_opt: assert property (
        conv_end && !chain_mode |=> busy_bit_en == $past(~cnv_s | ~sdi_s))
        else $error("cs start bit option wrong at conversion end");
    chk_chain_busy_opt: assert property (
        cnv_rise && !conv_busy && !sdi_d |=> busy_bit_en == $past(sck_d))
        else $error("chain start bit option not from clock level");
    chk_cs_framing: assert property (
        !result_output_oe_n && !chain_mode |-> (!cnv_s || !sdi_s))
        else $error("output driven outside cs frame");
    chk_conv_internal: assert property (
        $fell(conv_busy) |-> busy_len == TMR_W'(CONV_CYC))
        else $error("conversion length wrong");
    chk_clamp: assert property (
        conv_end && core_over && !busy_now |=> sh[asi_pkg::SH_W-1:1] == asi_pkg::CODE_POS_FS)
        else $error("overrange not clamped");
    chk_release_rise: assert property (
        cnv_rise && !conv_busy |=> result_output_oe_n && conv_busy)
        else $error("output not released at trigger rise");
    chk_bit_limit: assert property (
        !chain_mode && state == asi_pkg::ST_READY && cnt == limit |-> result_output_oe_n)
        else $error("output driven past last bit");
    chk_mode_hold: assert property (
        !cnv_rise |=> $stable(chain_mode))
        else $error("mode changed without trigger");
    chk_msb_first: assert property (
        drive && sck_fall && !chain_mode |=> result_output == $past(sh[asi_pkg::SH_W-2]))
        else $error("shift order wrong");
    chk_chain_pass: assert property (
        drive && sck_fall && chain_mode |=> (busy_bit_en ? sh[0] : sh[1]) == $past(sdi_s))
        else $error("upstream data not shifted in");

    cov_cs_plain: cover property (conv_end && !chain_mode && !busy_now);
    cov_cs_busy: cover property (conv_end && !chain_mode && busy_now);
    cov_chain: cover property (drive && chain_mode && sck_fall);
    cov_full_read: cover property (!chain_mode && cnt == asi_pkg::BITS_PLAIN);
endmodule : asi_serial_if

// [testbench/asi_host_model.sv]
// host-side model driving the trigger, select/chain and serial clock pins
// assumes mclk is the bench clock; pins change only on its falling edge
`timescale 1ns/10ps
module asi_host_model (
    input wire logic mclk,
    output logic conversion_trigger,
    output logic select_chain_input,
    output logic sclk,
    input wire logic result_output,
    input wire logic result_output_oe_n
);
    logic line;
    // a released line floats up to the pull-up level
    assign line = result_output_oe_n ? 1'h1 : result_output;
    // idle pins: trigger and select high, clock parked low
    initial begin
        conversion_trigger = 1'h1;
        select_chain_input = 1'h1;
        sclk = 1'h0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle
    // long low time first so any conversion in flight is over
    task automatic trig(input logic s, input logic tied, input logic k);
        conversion_trigger = 1'h0;
        select_chain_input = s;
        sclk = k;
        idle(30);
        conversion_trigger = 1'h1;
        if (tied) select_chain_input = 1'h1;
        idle(5);
        sclk = 1'h0;
    endtask : trig
    // frame on the trigger line or on the select line
    task automatic frame(input logic by_sel, input logic lvl);
        if (by_sel) select_chain_input = lvl;
        else conversion_trigger = lvl;
    endtask : frame
    // one serial clock period of 8 mclk, data taken after the fall
    task automatic fall();
        sclk = 1'h1;
        idle(4);
        sclk = 1'h0;
        idle(4);
    endtask : fall
    task automatic rd(input int n, output logic [19:0] v);
        v = 20'h0;
        idle(4);
        for (int i = 0; i < n; i++) begin
            if (i != 0) fall();
            v = {v[18:0], line};
        end
    endtask : rd
endmodule : asi_host_model

// [testbench/adc_serial_mode_interface_tb.sv]
// self-checking bench: one conversion and readout per call of run
// assumes the host model owns the serial pins and the bench owns the core code
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
module adc_serial_mode_interface_tb;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic trg, sel, sck, dout, oe_n, busy, chain, ben;
    logic over = 1'h0;
    logic under = 1'h0;
    logic [17:0] code = 18'h0;
    logic [17:0] val;
    logic [19:0] v;
    int n_errors = 0;
    int num_checks = 0;
    // 20 MHz master clock
    always #25 mclk = ~mclk;
    asi_serial_if asi_serial_if_i (.mclk(mclk), .rst(rst), .conversion_trigger(trg),
        .select_chain_input(sel), .sclk(sck), .core_code(code), .core_over(over),
        .core_under(under), .result_output(dout), .result_output_oe_n(oe_n),
        .conv_busy(busy), .chain_mode(chain), .busy_bit_en(ben));
    asi_host_model asi_host_model_i (.mclk(mclk), .conversion_trigger(trg),
        .select_chain_input(sel), .sclk(sck), .result_output(dout),
        .result_output_oe_n(oe_n));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // s/t/k: select, tied, clock at trigger; e: frame early; f: frame by select
    task automatic run(input logic s, t, k, e, f, m, b, input logic [17:0] c,
            input logic o, u);
        code = c;
        over = o;
        under = u;
        val = o ? 18'h1FFFF : (u ? 18'h20000 : c);
        asi_host_model_i.trig(s, t, k);
        `CHK(oe_n, 1'h1)
        `CHK(busy, 1'h1)
        `CHK(chain, m)
        if (e) asi_host_model_i.frame(f, 1'h0);
        // bounded wait for the end of conversion before reading
        for (int i = 0; i < 100 && busy !== 1'h0; i++) @(negedge mclk);
        `CHK(busy, 1'h0)
        `CHK(ben, b)
        if (!e) asi_host_model_i.frame(f, 1'h0);
        if (m) asi_host_model_i.frame(1'h1, 1'h1);
        asi_host_model_i.rd(b ? 19 : 18, v);
        if (b) `CHK(v, {1'h0, m ? asi_pkg::START_CHAIN : asi_pkg::START_CS, val})
        else `CHK(v, {2'h0, val})
        asi_host_model_i.fall();
        if (!m) `CHK(oe_n, 1'h1)
        if (m) `CHK(asi_host_model_i.line, 1'h1)
    endtask : run
    // reset for 8 cycles, then every mode and start-bit option at least once
    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'h0;
        run(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 18'h2A5C3, 1'h0, 1'h0);
        run(1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 18'h00001, 1'h1, 1'h0);
        run(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 18'h3FFFF, 1'h0, 1'h1);
        run(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 18'h15A3C, 1'h0, 1'h0);
        run(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 18'h0F0F0, 1'h0, 1'h0);
        run(1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 18'h30C0F, 1'h0, 1'h0);
        run(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 18'h1FFFE, 1'h1, 1'h1);
        report_and_stop();
    end
    // watchdog: the runs take well under a tenth of this span
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
endmodule : adc_serial_mode_interface_tb
